// File: inc/srp_pkg.sv
// Constants shared by both ends of the serial register port
package srp_pkg;
  // Frame layout
  localparam int FRAME_BITS = 24;
  localparam int INSTR_BITS = 8;
  localparam logic [4:0] CNT_INSTR_LAST = 5'h07;
  localparam logic [4:0] CNT_DATA_LAST = 5'h17;
  localparam logic [4:0] CNT_FRAME_END = 5'h18;
  // Device register map
  localparam int REG_COUNT = 14;
  localparam logic [6:0] ADDR_CFG0 = 7'h00;
  localparam logic [6:0] ADDR_EVENTS = 7'h05;
  localparam logic [6:0] ADDR_SENSOR = 7'h06;
  localparam logic [6:0] ADDR_SYNC_LAST = 7'h09;
  localparam int FOUR_WIRE_BIT = 9;
  localparam int ALIGN_RX_BIT = 4;
  localparam int SYNC_RX_BIT = 3;
  localparam logic [15:0] REG_RESET [REG_COUNT] = '{
    16'h44fc, 16'h600e, 16'h3fff, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'hffff, 16'h4000, 16'h8000, 16'hf080, 16'h1111, 16'h3a7a, 16'h36b6};
  // Host timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int RESET_PULSE_NS = 25;
  localparam logic [3:0] RESET_PULSE_CYC =
    4'((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] SCLK_HALF_CYC = 4'h8;
  // Host AXI4-Lite map
  localparam logic [7:0] AXI_CMD = 8'h00;
  localparam logic [7:0] AXI_STATUS = 8'h04;
  localparam logic [7:0] AXI_RDATA = 8'h08;
  localparam logic [7:0] AXI_CTRL = 8'h0c;
  localparam int CMD_ADDR_LSB = 16;
  localparam int CMD_RW_BIT = 23;
  localparam int CTRL_FOUR_WIRE_BIT = 0;
  localparam int CTRL_GATE_BIT = 1;
  localparam int CTRL_RESET_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: inc/srp_if.sv
// Pins between the serial host and the register port
`timescale 1ns/10ps
interface srp_if;
  logic sclk;
  logic frame_n;
  logic sdio_host_o;
  logic sdio_host_oe;
  logic sdio_dev_o;
  logic sdio_dev_oe;
  logic sdo_o;
  logic sdo_oe;
  logic sdio;
  logic serial_out_pin;
  logic chip_reset_n;
  logic transmit_output_gate;
  logic align_in_pos;
  logic align_in_neg;
  logic sync_in_pos;
  logic sync_in_neg;

  // Undriven lines float high, as with a weak pull-up
  assign sdio = sdio_host_oe ? sdio_host_o :
                sdio_dev_oe ? sdio_dev_o : 1'b1;
  assign serial_out_pin = sdo_oe ? sdo_o : 1'b1;

  modport device (
    input sclk, frame_n, sdio, chip_reset_n, transmit_output_gate,
    output sdio_dev_o, sdio_dev_oe, sdo_o, sdo_oe
  );
  modport host (
    input sdio, serial_out_pin,
    output sclk, frame_n, sdio_host_o, sdio_host_oe, chip_reset_n,
    output transmit_output_gate, align_in_pos, align_in_neg,
    output sync_in_pos, sync_in_neg
  );
endinterface

// File: logic/srp_device.sv
// Device end of the serial register port with its register file
//
// Function
// - Config bit 9 picks three or four wires
// - Three-wire data pin carries both directions
// - Four-wire: data pin both ways, output pin copies read data
// - Sample on rising, launch on falling edges
// - Host holds frame enable low whole access
// - Instruction byte: read flag, 7-bit address
// - Flag one reads, flag zero writes
// - Data phase is exactly two bytes
// - Three-wire read: output pin stays released
// - Four-wire read: both pins drive data
// - Drive low after last bit until frame ends
// - Normal register updates all bits at once
// - Autosync group emits pulse after last write
// - Sensor register has no fixed reset value
// - Readback defaults assume no blown fuses
// - Read-only register passes inputs, no storage
// - Write-to-clear bits hold until written zero
// - Host ties unused align pair, clears enable
// - Host clears sync enable if pair unused
// - Host start-up order with 25 ns reset
// - Host initialises pointers before output gate
`timescale 1ns/10ps
module srp_device (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial pins
  srp_if.device bus,
  // Register contents
  output logic [15:0] reg_word [srp_pkg::REG_COUNT],
  output logic four_wire_select,
  output logic sync_rx_enable,
  output logic align_rx_enable,
  output logic autosync_pulse,
  output logic output_gate,
  // Internal sources
  input wire logic [15:0] event_in,
  input wire logic [15:0] sensor_fuse_readback
);
  // Synchroniser order: sclk, frame_n, sdio, chip reset, gate
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic sclk_prev_q;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_act;
  logic sdio_s;
  logic soft_rst;
  logic [4:0] cnt_q;
  logic [22:0] shift_in_q;
  logic [7:0] instr_q;
  logic wr_stb_q;
  logic [6:0] wr_addr_q;
  logic [15:0] wr_data_q;
  logic [15:0] rdata_q;
  logic [15:0] rd_mux;
  logic [6:0] rd_addr;
  logic out_q;
  logic drv_q;
  logic sync_pulse_q;
  logic [15:0] reg_val [srp_pkg::REG_COUNT];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= 5'h0a;
      sync_q <= 5'h0a;
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= {bus.sclk, bus.frame_n, bus.sdio, bus.chip_reset_n,
                 bus.transmit_output_gate};
      sync_q <= meta_q;
      sclk_prev_q <= sync_q[4];
    end
  end

  assign sclk_rise = sync_q[4] & ~sclk_prev_q;
  assign sclk_fall = ~sync_q[4] & sclk_prev_q;
  // Frame enable gates every step of the shifter
  assign frame_act = ~sync_q[3];
  assign sdio_s = sync_q[2];
  assign soft_rst = ~sync_q[1];

  // Bit counter; extra clocks past the frame end are ignored
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !frame_act)
      cnt_q <= 5'h00;
    else if (sclk_rise && cnt_q != srp_pkg::CNT_FRAME_END)
      cnt_q <= cnt_q + 5'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      shift_in_q <= 23'h000000;
    else if (frame_act && sclk_rise)
      shift_in_q <= {shift_in_q[21:0], sdio_s};
  end

  // Instruction: read flag then seven address bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !frame_act)
      instr_q <= 8'h00;
    else if (sclk_rise && cnt_q == srp_pkg::CNT_INSTR_LAST)
      instr_q <= {shift_in_q[6:0], sdio_s};
  end

  // Writes land only when all sixteen data bits arrived
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_stb_q <= 1'b0;
      wr_addr_q <= 7'h00;
      wr_data_q <= 16'h0000;
    end
    else
    begin
      wr_stb_q <= frame_act && sclk_rise && !instr_q[7] &&
                  cnt_q == srp_pkg::CNT_DATA_LAST;
      if (frame_act && sclk_rise && cnt_q == srp_pkg::CNT_DATA_LAST)
      begin
        wr_addr_q <= instr_q[6:0];
        wr_data_q <= {shift_in_q[14:0], sdio_s};
      end
    end
  end

  // Register file, one entry per address
  genvar gi;
  generate
    for (gi = 0; gi < srp_pkg::REG_COUNT; gi = gi + 1)
    begin : g_reg
      if (gi == int'(srp_pkg::ADDR_SENSOR))
      begin : g_ro
        // Sensor and fuse state, so no reset value exists
        assign reg_val[gi] = sensor_fuse_readback;
      end
      else if (gi == int'(srp_pkg::ADDR_EVENTS))
      begin : g_w2c
        // New events win over a clear in the same cycle
        always_ff @(posedge aclk)
        begin
          if (!aresetn || soft_rst)
            reg_val[gi] <= srp_pkg::REG_RESET[gi];
          else if (wr_stb_q && wr_addr_q == 7'(gi))
            reg_val[gi] <= (reg_val[gi] & wr_data_q) | event_in;
          else
            reg_val[gi] <= reg_val[gi] | event_in;
        end
      end
      else
      begin : g_rw
        // Defaults are the unfused values
        always_ff @(posedge aclk)
        begin
          if (!aresetn || soft_rst)
            reg_val[gi] <= srp_pkg::REG_RESET[gi];
          else if (wr_stb_q && wr_addr_q == 7'(gi))
            reg_val[gi] <= wr_data_q;
        end
      end
      assign reg_word[gi] = reg_val[gi];
    end
  endgenerate

  // Each offset word updates when written; pulse rises as the last word lands
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sync_pulse_q <= 1'b0;
    else
      sync_pulse_q <= wr_stb_q && wr_addr_q == srp_pkg::ADDR_SYNC_LAST;
  end

  // Address known at the last instruction bit
  assign rd_addr = {shift_in_q[5:0], sdio_s};

  always_comb
  begin
    rd_mux = 16'h0000;
    if (rd_addr < 7'(srp_pkg::REG_COUNT))
      rd_mux = reg_val[rd_addr[3:0]];
  end

  // Read word loads on the rise, shifts out on each fall
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rdata_q <= 16'h0000;
    else if (frame_act && sclk_rise && cnt_q == srp_pkg::CNT_INSTR_LAST)
      rdata_q <= rd_mux;
    else if (frame_act && sclk_fall && cnt_q > srp_pkg::CNT_INSTR_LAST)
      rdata_q <= {rdata_q[14:0], 1'b0};
  end

  // Drivers on from the first data fall until frame_n rises
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !frame_act)
    begin
      out_q <= 1'b0;
      drv_q <= 1'b0;
    end
    else if (sclk_fall && instr_q[7] &&
             cnt_q > srp_pkg::CNT_INSTR_LAST)
    begin
      drv_q <= 1'b1;
      if (cnt_q == srp_pkg::CNT_FRAME_END)
        out_q <= 1'b0;
      else
        out_q <= rdata_q[15];
    end
  end

  assign four_wire_select = reg_val[0][srp_pkg::FOUR_WIRE_BIT];
  assign sync_rx_enable = reg_val[0][srp_pkg::SYNC_RX_BIT];
  assign align_rx_enable = reg_val[0][srp_pkg::ALIGN_RX_BIT];
  assign autosync_pulse = sync_pulse_q;
  assign output_gate = sync_q[0];

  assign bus.sdio_dev_o = out_q;
  assign bus.sdio_dev_oe = drv_q;
  assign bus.sdo_o = out_q;
  assign bus.sdo_oe = drv_q & four_wire_select;
endmodule

// File: logic/srp_host.sv
// Host end: AXI4-Lite controlled serial master
`timescale 1ns/10ps
module srp_host (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial pins
  srp_if.host bus,
  // AXI4-Lite write
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  typedef enum {ST_IDLE, ST_SHIFT, ST_HOLD, ST_GAP} srp_state_t;
  srp_state_t st_q;
  logic [7:0] aw_q;
  logic aw_got_q;
  logic [31:0] w_q;
  logic w_got_q;
  logic [2:0] ctrl_q;
  logic [3:0] rst_cnt_q;
  logic [23:0] word_q;
  logic [15:0] rx_q;
  logic [4:0] cnt_q;
  logic [3:0] div_q;
  logic tick;
  logic sclk_q;
  logic frame_n_q;
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic rx_bit;
  logic do_wr;
  logic start;
  logic rw_q;

  // Address and data taken in either order
  assign s_awready = ~aw_got_q;
  assign s_wready = ~w_got_q;
  assign do_wr = aw_got_q && w_got_q && !s_bvalid;
  assign start = do_wr && aw_q == srp_pkg::AXI_CMD && st_q == ST_IDLE;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h00000000;
      s_bvalid <= 1'b0;
      s_bresp <= srp_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_got_q <= 1'b1;
        aw_q <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        w_got_q <= 1'b1;
        w_q <= s_wdata;
      end
      if (do_wr)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_bvalid <= 1'b1;
        // Busy engine or unknown offset is refused
        if (start || aw_q == srp_pkg::AXI_CTRL)
          s_bresp <= srp_pkg::RESP_OKAY;
        else
          s_bresp <= srp_pkg::RESP_SLVERR;
      end
      else if (s_bready)
        s_bvalid <= 1'b0;
    end
  end

  // Gate stays where software puts it; it orders the start-up
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= 3'h0;
      rst_cnt_q <= 4'h0;
    end
    else
    begin
      if (do_wr && aw_q == srp_pkg::AXI_CTRL && s_wstrb[0])
        ctrl_q <= w_q[2:0];
      if (do_wr && aw_q == srp_pkg::AXI_CTRL && s_wstrb[0] &&
          w_q[srp_pkg::CTRL_RESET_BIT])
        rst_cnt_q <= srp_pkg::RESET_PULSE_CYC;
      else if (rst_cnt_q != 4'h0)
        rst_cnt_q <= rst_cnt_q - 4'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= srp_pkg::RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_rvalid <= 1'b1;
      s_rresp <= srp_pkg::RESP_OKAY;
      if (s_araddr == srp_pkg::AXI_STATUS)
        s_rdata <= {30'h0, rst_cnt_q != 4'h0, st_q != ST_IDLE};
      else if (s_araddr == srp_pkg::AXI_RDATA)
        s_rdata <= {16'h0000, rx_q};
      else if (s_araddr == srp_pkg::AXI_CTRL)
        s_rdata <= {29'h0, ctrl_q};
      else if (s_araddr == srp_pkg::AXI_CMD)
        s_rdata <= {8'h00, word_q};
      else
      begin
        s_rdata <= 32'h00000000;
        s_rresp <= srp_pkg::RESP_SLVERR;
      end
    end
    else if (s_rready)
      s_rvalid <= 1'b0;
  end
  assign s_arready = ~s_rvalid;

  // Half-period divider for the serial clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn || st_q == ST_IDLE || tick)
      div_q <= 4'h1;
    else
      div_q <= div_q + 4'h1;
  end
  assign tick = div_q == srp_pkg::SCLK_HALF_CYC;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
    end
    else
    begin
      meta_q <= {bus.sdio, bus.serial_out_pin};
      sync_q <= meta_q;
    end
  end
  assign rx_bit = ctrl_q[srp_pkg::CTRL_FOUR_WIRE_BIT] ? sync_q[0] :
                  sync_q[1];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= ST_IDLE;
      sclk_q <= 1'b0;
      frame_n_q <= 1'b1;
      cnt_q <= 5'h00;
      word_q <= 24'h000000;
      rx_q <= 16'h0000;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
          if (start)
          begin
            word_q <= w_q[23:0];
            cnt_q <= 5'h00;
            frame_n_q <= 1'b0;
            st_q <= ST_SHIFT;
          end
        ST_SHIFT:
          if (tick)
          begin
            sclk_q <= ~sclk_q;
            if (!sclk_q)
            begin
              // Sample on the rise, data bits only, in reads and writes alike
              cnt_q <= cnt_q + 5'h01;
              if (cnt_q > srp_pkg::CNT_INSTR_LAST)
                rx_q <= {rx_q[14:0], rx_bit};
            end
            else
            begin
              word_q <= {word_q[22:0], 1'b0};
              if (cnt_q == srp_pkg::CNT_FRAME_END)
                st_q <= ST_HOLD;
            end
          end
        ST_HOLD:
          if (tick)
          begin
            frame_n_q <= 1'b1;
            st_q <= ST_GAP;
          end
        ST_GAP:
          if (tick)
            st_q <= ST_IDLE;
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  assign bus.sclk = sclk_q;
  assign bus.frame_n = frame_n_q;
  assign bus.sdio_host_o = word_q[23];
  // Released for read data so the device may drive
  // Held through the high half of the last address bit: the device
  // samples late, and an early release would corrupt that bit
  assign bus.sdio_host_oe = st_q == ST_SHIFT &&
    (cnt_q <= srp_pkg::CNT_INSTR_LAST || !rw_q ||
     (cnt_q == srp_pkg::CNT_INSTR_LAST + 5'h01 && sclk_q));
  assign bus.chip_reset_n = rst_cnt_q == 4'h0;
  assign bus.transmit_output_gate = ctrl_q[srp_pkg::CTRL_GATE_BIT];
  // Unused sync and align pairs held at fixed levels
  assign bus.align_in_pos = 1'b1;
  assign bus.align_in_neg = 1'b0;
  assign bus.sync_in_pos = 1'b0;
  assign bus.sync_in_neg = 1'b0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rw_q <= 1'b0;
    else if (start)
      rw_q <= w_q[srp_pkg::CMD_RW_BIT];
  end
endmodule

// File: verification/srp_assertions.sv
// Checker on the pins between the two ends of the serial register port
`timescale 1ns/10ps
module srp_assertions (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial pins
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic sdio,
  input wire logic sdio_host_oe,
  input wire logic sdio_dev_o,
  input wire logic sdio_dev_oe,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  logic sclk_q;
  logic read_q;
  logic [4:0] rises_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Rising serial edges seen in the current frame
  always_ff @(posedge aclk)
  begin
    sclk_q <= sclk;
    if (!aresetn || frame_n)
      rises_q <= 5'h00;
    else if (sclk && !sclk_q)
      rises_q <= rises_q + 5'h01;
  end

  // First bit of the frame is the read flag
  always_ff @(posedge aclk)
  begin
    if (!frame_n && sclk && !sclk_q && rises_q == 5'h00)
      read_q <= sdio;
  end

  property p_one_driver; !(sdio_host_oe && sdio_dev_oe); endproperty
  a_one_driver: assert property (p_one_driver)
    else $error("data pin driven by both ends");
  property p_sdo_copy; sdo_oe |-> sdio_dev_oe && sdo_o == sdio_dev_o;
  endproperty
  a_sdo_copy: assert property (p_sdo_copy)
    else $error("output pin differs from data pin");
  property p_drive_start;
    $rose(sdio_dev_oe) |-> !frame_n && read_q && rises_q == 5'h08;
  endproperty
  a_drive_start: assert property (p_drive_start)
    else $error("device drives outside read data phase");
  property p_write_quiet; rises_q != 5'h00 && !read_q |-> !sdio_dev_oe;
  endproperty
  a_write_quiet: assert property (p_write_quiet)
    else $error("device drives during a write");
  property p_host_lets_go;
    read_q && rises_q >= 5'h09 |-> !sdio_host_oe;
  endproperty
  a_host_lets_go: assert property (p_host_lets_go)
    else $error("host still drives in read data phase");
  property p_launch_fall;
    sdio_dev_oe && $past(sdio_dev_oe) && sdio_dev_o != $past(sdio_dev_o)
      |-> !sclk;
  endproperty
  a_launch_fall: assert property (p_launch_fall)
    else $error("read bit changed while serial clock high");
  property p_low_at_end; $rose(frame_n) && sdio_dev_oe |-> !sdio_dev_o;
  endproperty
  a_low_at_end: assert property (p_low_at_end)
    else $error("data pin not low at frame end");
  property p_released; frame_n [*8] |-> !sdio_dev_oe && !sdo_oe;
  endproperty
  a_released: assert property (p_released)
    else $error("device pins not released after frame");
  property p_frame_len; $rose(frame_n) |-> rises_q == 5'h18; endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame without 24 clock rises");
  property p_clock_idle; frame_n |-> !sclk; endproperty
  a_clock_idle: assert property (p_clock_idle)
    else $error("serial clock moves outside a frame");

  c_four_wire: cover property ($rose(sdo_oe));
  c_read: cover property ($rose(sdio_dev_oe));
  c_write: cover property ($rose(frame_n) && !read_q);
endmodule

// File: verification/serial_register_port_bench.sv
// Bench joining both ends of the serial register port
`timescale 1ns/10ps
module serial_register_port_bench;
  typedef struct packed {
    logic fw;
    logic rw;
    logic [6:0] a;
    logic [15:0] d;
    logic [15:0] x;
  } srp_row_t;
  // Four-wire flag, read flag, address, write data, expected word
  localparam srp_row_t ROWS [9] = '{
    '{1'b0, 1'b0, 7'h01, 16'ha5c3, 16'ha5c3},
    '{1'b0, 1'b1, 7'h01, 16'h0000, 16'ha5c3},
    '{1'b0, 1'b1, 7'h0d, 16'h0000, 16'h36b6},
    '{1'b0, 1'b0, 7'h00, 16'h46fc, 16'h46fc},
    '{1'b1, 1'b1, 7'h00, 16'h0000, 16'h46fc},
    '{1'b1, 1'b0, 7'h0c, 16'h1234, 16'h1234},
    '{1'b1, 1'b1, 7'h0c, 16'h0000, 16'h1234},
    '{1'b1, 1'b0, 7'h00, 16'h44e4, 16'h44e4},
    '{1'b0, 1'b1, 7'h0b, 16'h0000, 16'h1111}};
  logic aclk;
  logic aresetn;
  logic [7:0] s_awaddr;
  logic s_awvalid;
  logic s_awready;
  logic [31:0] s_wdata;
  logic [3:0] s_wstrb;
  logic s_wvalid;
  logic s_wready;
  logic [1:0] s_bresp;
  logic s_bvalid;
  logic s_bready;
  logic [7:0] s_araddr;
  logic s_arvalid;
  logic s_arready;
  logic [31:0] s_rdata;
  logic [1:0] s_rresp;
  logic s_rvalid;
  logic s_rready;
  logic [15:0] reg_word [srp_pkg::REG_COUNT];
  logic four_wire_select;
  logic sync_rx_enable;
  logic align_rx_enable;
  logic autosync_pulse;
  logic output_gate;
  logic [15:0] event_in;
  logic [15:0] sensor_fuse_readback;
  logic [31:0] rd;
  logic [1:0] rs;
  int err_count;
  int comparisons;
  int pulses;

  srp_if bus_if ();
  srp_device srp_device_i (.aclk, .aresetn, .bus(bus_if), .reg_word,
    .four_wire_select, .sync_rx_enable, .align_rx_enable, .autosync_pulse,
    .output_gate, .event_in, .sensor_fuse_readback);
  srp_host srp_host_i (.aclk, .aresetn, .bus(bus_if), .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready);
  srp_assertions srp_assertions_i (.aclk, .aresetn, .sclk(bus_if.sclk),
    .frame_n(bus_if.frame_n), .sdio(bus_if.sdio),
    .sdio_host_oe(bus_if.sdio_host_oe), .sdio_dev_o(bus_if.sdio_dev_o),
    .sdio_dev_oe(bus_if.sdio_dev_oe), .sdo_o(bus_if.sdo_o),
    .sdo_oe(bus_if.sdo_oe));

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  always @(posedge aclk)
    if (autosync_pulse === 1'b1)
      pulses++;

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_awready === 1'b1)
        s_awvalid <= 1'b0;
      if (s_wready === 1'b1)
        s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    rs = s_bresp;
    s_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_arready === 1'b1)
        s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    rd = s_rdata;
    rs = s_rresp;
    s_rready <= 1'b0;
  endtask

  task automatic wait_idle();
    do
      axi_rd(srp_pkg::AXI_STATUS);
    while (rd[0] !== 1'b0);
  endtask

  // One serial frame; a read leaves the word in rd
  task automatic frame(input logic rw, input logic [6:0] a,
    input logic [15:0] d);
    axi_wr(srp_pkg::AXI_CMD, {8'h00, rw, a, d});
    wait_idle();
    if (rw)
      axi_rd(srp_pkg::AXI_RDATA);
  endtask

  task automatic close_out();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Sixteen frames of some 450 cycles each, with wide margin
  initial
  begin
    repeat (40000) @(posedge aclk);
    err_count++;
    close_out();
  end

  initial
  begin
    aresetn = 1'b0;
    {s_awaddr, s_awvalid, s_wdata, s_wvalid, s_bready} = '0;
    {s_araddr, s_arvalid, s_rready} = '0;
    s_wstrb = 4'hf;
    event_in = 16'h0000;
    sensor_fuse_readback = 16'h0000;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ROWS[i])
    begin
      axi_wr(srp_pkg::AXI_CTRL, {31'h0, ROWS[i].fw});
      chk_w({31'h0, four_wire_select}, {31'h0, ROWS[i].fw});
      frame(ROWS[i].rw, ROWS[i].a, ROWS[i].d);
      if (ROWS[i].rw)
        chk_w({16'h0, rd[15:0]}, {16'h0, ROWS[i].x});
      chk_w({16'h0, reg_word[ROWS[i].a]}, {16'h0, ROWS[i].x});
    end
    chk_w({31'h0, sync_rx_enable | align_rx_enable}, 32'h0);
    // Events captured and cleared bit by bit
    event_in <= 16'h0009;
    @(posedge aclk);
    event_in <= 16'h0000;
    frame(1'b1, srp_pkg::ADDR_EVENTS, 16'h0000);
    chk_w({16'h0, rd[15:0]}, 32'h0009);
    frame(1'b0, srp_pkg::ADDR_EVENTS, 16'hfffe);
    frame(1'b1, srp_pkg::ADDR_EVENTS, 16'h0000);
    chk_w({16'h0, rd[15:0]}, 32'h0008);
    // Read-only word follows its source with no storage
    sensor_fuse_readback <= 16'h5a3c;
    frame(1'b1, srp_pkg::ADDR_SENSOR, 16'h0000);
    chk_w({16'h0, rd[15:0]}, 32'h5a3c);
    sensor_fuse_readback <= 16'h0f0f;
    #1;
    chk_w({16'h0, reg_word[6]}, 32'h0f0f);
    // Pulse only after the last word of the group
    pulses = 0;
    frame(1'b0, 7'h08, 16'h0123);
    chk_w(pulses, 32'h0);
    frame(1'b0, srp_pkg::ADDR_SYNC_LAST, 16'h8456);
    chk_w(pulses, 32'h1);
    // Second order while busy is refused and dropped
    axi_wr(srp_pkg::AXI_CMD, 32'h000c_0042);
    axi_wr(srp_pkg::AXI_CMD, 32'h000c_dead);
    chk_w({30'h0, rs}, {30'h0, srp_pkg::RESP_SLVERR});
    wait_idle();
    chk_w({16'h0, reg_word[12]}, 32'h0042);
    axi_rd(8'h10);
    chk_w(rd, 32'h0);
    chk_w({30'h0, rs}, {30'h0, srp_pkg::RESP_SLVERR});
    axi_wr(8'h20, 32'h1);
    chk_w({30'h0, rs}, {30'h0, srp_pkg::RESP_SLVERR});
    // Output gate, then chip reset brings back every default
    axi_wr(srp_pkg::AXI_CTRL, 32'h2);
    repeat (4) @(posedge aclk);
    chk_w({31'h0, output_gate}, 32'h1);
    axi_wr(srp_pkg::AXI_CTRL, 32'h4);
    axi_rd(srp_pkg::AXI_STATUS);
    chk_w(rd, 32'h2);
    repeat (12) @(posedge aclk);
    for (int k = 0; k < srp_pkg::REG_COUNT; k++)
      if (k != 6)
        chk_w({16'h0, reg_word[k]}, {16'h0, srp_pkg::REG_RESET[k]});
    chk_w({31'h0, output_gate}, 32'h0);
    close_out();
  end
endmodule
